// File: shared/dtec_defs.svh
// Constants for the dual timer/event counter: register offsets, field
// positions, reset values and the instruction clock divider.
// Assumes it is included by the package and the design file by bare name.
`ifndef DTEC_DEFS_SVH
`define DTEC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the byte-wide register port
// ----------------------------------------------------------------------
`define DTEC_ADDR_CNT0_HIGH  8'h0C
`define DTEC_ADDR_CNT0_LOW   8'h0D
`define DTEC_ADDR_CNT0_CTRL  8'h0E
`define DTEC_ADDR_CNT1_HIGH  8'h0F
`define DTEC_ADDR_CNT1_LOW   8'h10
`define DTEC_ADDR_CNT1_CTRL  8'h11
`define DTEC_ADDR_IRQ_CTRL   8'h2F

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DTEC_CTRL_EDGE_BIT   3
`define DTEC_CTRL_RUN_BIT    4
`define DTEC_CTRL_MODE_HI    7
`define DTEC_CTRL_MODE_LO    6
`define DTEC_CTRL_IMPL_MASK  8'hD8
`define DTEC_CTRL_RST        8'h08

// ----------------------------------------------------------------------
// Interrupt control register fields
// ----------------------------------------------------------------------
`define DTEC_IRQ_EN0_BIT     0
`define DTEC_IRQ_EN1_BIT     1
`define DTEC_IRQ_FLAG0_BIT   5
`define DTEC_IRQ_FLAG1_BIT   6

// ----------------------------------------------------------------------
// Mode codes, counter limits and instruction clock
// ----------------------------------------------------------------------
`define DTEC_MODE_OFF        2'h0
`define DTEC_MODE_EVENT      2'h1
`define DTEC_MODE_TIMER      2'h2
`define DTEC_MODE_PULSE      2'h3
`define DTEC_COUNT_MAX       16'hFFFF
`define DTEC_COUNT_ONE       16'h0001
`define DTEC_ICLK_DIV        4
`define DTEC_DIV_LAST        2'(`DTEC_ICLK_DIV - 1)

`endif

// File: shared/dtec_pkg.sv
// Types shared by the dual timer/event counter design.
// Assumes dtec_defs.svh is reachable on the include path.
`include "dtec_defs.svh"

package dtec_pkg;

  // ----------------------------------------------------------------------
  // Operating mode held in the top two control bits
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF   = `DTEC_MODE_OFF,
    MODE_EVENT = `DTEC_MODE_EVENT,
    MODE_PULSE = `DTEC_MODE_PULSE,
    MODE_TIMER = `DTEC_MODE_TIMER
  } dtec_mode_t;

  // ----------------------------------------------------------------------
  // Pulse-width measurement state
  // ----------------------------------------------------------------------
  typedef enum logic {
    PW_WAIT  = 1'b0,
    PW_COUNT = 1'b1
  } dtec_pw_t;

  // ----------------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        div;
    logic [1:0]        pin_s1;
    logic [1:0]        pin_s2;
    logic [1:0]        pin_prev;
    logic [1:0][15:0]  count;
    logic [1:0][15:0]  preload;
    logic [1:0][7:0]   hold;
    logic [1:0][7:0]   ctrl;
    dtec_pw_t [1:0]    pw;
    logic [1:0]        flag;
    logic [1:0]        irq_en;
    logic [1:0]        irq;
    logic [1:0]        wake;
    logic [7:0]        rdata;
  } dtec_state_t;

endpackage : dtec_pkg

// File: src/dtec_top.sv
// Two independent 16-bit count-up timer/event counters with preload,
// byte-wide register port, overflow flags, interrupt requests and wake-up.
// Assumes a synchronous register master on mclk and asynchronous count pins.
//
// Contract
// (R1) Each counter is 16-bit up-counter, clocked by pin or mclk divided by four.
// (R2) Low-byte write stores into holding buffer only.
// (R3) High-byte write loads preload high byte and buffer into preload low byte.
// (R4) High-byte read returns counter high byte and captures low byte into buffer.
// (R5) Low-byte read returns holding buffer, not the live counter.
// (R6) Control bits 7:6 select mode: 01 event, 10 timer, 11 pulse, 00 unused.
// (R7) Control bit 3 selects pin edge: 0 rising, 1 falling.
// (R8) Control bit 4 is run enable.
// (R9) Control bits 2:0 and 5 read as zero.
// (R10) Event mode counts selected pin edges; timer mode counts instruction clocks.
// (R11) Overflow past FFFF reloads preload and sets that counter's interrupt flag.
// (R12) Pulse mode starts on transition, counts until pin returns, then clears run.
// (R13) After a pulse measurement the result holds until run is set again.
// (R14) Pulse mode overflow also reloads and raises the flag.
// (R15) In event and timer modes only software clears run.
// (R16) Overflow is a wake-up event for the processor.
// (R17) Cleared interrupt enable blocks that counter's interrupt in every mode.
// (R18) Preload write while stopped also loads the counter.
// (R19) Preload write while running leaves counter until next overflow.
// (R20) Counter clock is blocked during a read of that counter.
// (R21) Two identical independent counters share only the instruction clock.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "dtec_defs.svh"

module dtec_top (
  // Clock, reset and freeze.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Count pins, bit 0 for counter 0.
  input  wire logic [1:0]  count_pin,
  // Processor side.
  output logic      [1:0]  irq_request,
  output logic      [1:0]  wake_event
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dtec_pkg::dtec_state_t st;
  dtec_pkg::dtec_state_t next_st;
  logic [1:0]            ovf;
  logic [1:0]            tick;
  logic                  itick;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // One pass covers both counters; they only share the instruction tick.
  always_comb begin
    logic [7:0]             hi_a;
    logic [7:0]             lo_a;
    logic [7:0]             ct_a;
    logic                   run;
    logic                   edge_sel;
    logic                   rise;
    logic                   fall;
    logic                   start;
    logic                   stop;
    logic                   blocked;
    dtec_pkg::dtec_mode_t   mode;
    hi_a     = '0;
    lo_a     = '0;
    ct_a     = '0;
    run      = 1'b0;
    edge_sel = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    blocked  = 1'b0;
    mode     = dtec_pkg::MODE_OFF;
    next_st  = st;
    ovf      = '0;
    tick     = '0;
    // Instruction clock is one mclk in four.
    itick            = (st.div == `DTEC_DIV_LAST); // [R1]
    next_st.div      = st.div + 2'h1;
    // Pins pass two flops; the third stage only feeds the edge detectors.
    next_st.pin_s1   = count_pin;
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.rdata    = '0;
    next_st.wake     = '0;

    // Software write of enables and flags comes first so that an overflow
    // in the same cycle still sets its flag afterwards.
    if (wr && addr == `DTEC_ADDR_IRQ_CTRL) begin
      next_st.irq_en[0] = wdata[`DTEC_IRQ_EN0_BIT];
      next_st.irq_en[1] = wdata[`DTEC_IRQ_EN1_BIT];
      next_st.flag[0]   = wdata[`DTEC_IRQ_FLAG0_BIT];
      next_st.flag[1]   = wdata[`DTEC_IRQ_FLAG1_BIT];
    end

    for (int i = 0; i < 2; i++) begin // [R21]
      hi_a     = (i == 0) ? `DTEC_ADDR_CNT0_HIGH : `DTEC_ADDR_CNT1_HIGH;
      lo_a     = (i == 0) ? `DTEC_ADDR_CNT0_LOW : `DTEC_ADDR_CNT1_LOW;
      ct_a     = (i == 0) ? `DTEC_ADDR_CNT0_CTRL : `DTEC_ADDR_CNT1_CTRL;
      run      = st.ctrl[i][`DTEC_CTRL_RUN_BIT]; // [R8]
      edge_sel = st.ctrl[i][`DTEC_CTRL_EDGE_BIT];
      mode     = dtec_pkg::dtec_mode_t'(st.ctrl[i][`DTEC_CTRL_MODE_HI:`DTEC_CTRL_MODE_LO]); // [R6]
      rise     = st.pin_s2[i] & ~st.pin_prev[i];
      fall     = ~st.pin_s2[i] & st.pin_prev[i];
      // Reading either byte freezes the counter for that cycle; a pin edge
      // or instruction tick falling in it is lost.
      blocked  = rd && (addr == hi_a || addr == lo_a); // [R20]

      unique case (mode)
        dtec_pkg::MODE_EVENT: begin
          tick[i] = run & (edge_sel ? fall : rise); // [R7] [R10]
        end
        dtec_pkg::MODE_TIMER: begin
          tick[i] = run & itick; // [R10]
        end
        dtec_pkg::MODE_PULSE: begin
          // Edge bit one measures a high pulse, zero a low pulse.
          start = edge_sel ? rise : fall; // [R12]
          stop  = edge_sel ? fall : rise;
          unique case (st.pw[i])
            dtec_pkg::PW_WAIT: begin
              if (run && start) begin
                next_st.pw[i] = dtec_pkg::PW_COUNT; // [R12]
              end
            end
            dtec_pkg::PW_COUNT: begin
              if (!run) begin
                next_st.pw[i] = dtec_pkg::PW_WAIT;
              end else if (stop) begin
                // Dropping run leaves the result frozen until software sets it.
                next_st.pw[i]                        = dtec_pkg::PW_WAIT;
                next_st.ctrl[i][`DTEC_CTRL_RUN_BIT]  = 1'b0; // [R12] [R13]
              end else begin
                tick[i] = itick;
              end
            end
          endcase
        end
        dtec_pkg::MODE_OFF: begin
          tick[i] = 1'b0;
        end
      endcase
      if (mode != dtec_pkg::MODE_PULSE) begin
        next_st.pw[i] = dtec_pkg::PW_WAIT;
      end
      tick[i] = tick[i] & ~blocked; // [R20]

      // Count up; wrap reloads from preload and raises the flag.
      if (tick[i]) begin
        if (st.count[i] == `DTEC_COUNT_MAX) begin
          next_st.count[i] = st.preload[i]; // [R11] [R14]
          ovf[i]           = 1'b1;
        end else begin
          next_st.count[i] = st.count[i] + `DTEC_COUNT_ONE; // [R1]
        end
      end
      if (ovf[i]) begin
        next_st.flag[i] = 1'b1; // [R11] [R14]
        next_st.wake[i] = 1'b1; // [R16]
      end

      // Register writes for this counter.
      if (wr && addr == lo_a) begin
        next_st.hold[i] = wdata; // [R2]
      end
      if (wr && addr == hi_a) begin
        next_st.preload[i] = {wdata, st.hold[i]}; // [R3]
        if (!run) begin
          next_st.count[i] = {wdata, st.hold[i]}; // [R18]
        end
        // While running the count is left alone until the next wrap. [R19]
      end
      if (wr && addr == ct_a) begin
        // Only this write clears run in event and timer modes.
        next_st.ctrl[i] = wdata & `DTEC_CTRL_IMPL_MASK; // [R9] [R15]
      end
      if (rd && addr == hi_a) begin
        next_st.hold[i] = st.count[i][7:0]; // [R4]
      end
    end

    // Read data are registered and stand for one cycle only.
    if (rd) begin
      unique case (addr)
        `DTEC_ADDR_CNT0_HIGH: next_st.rdata = st.count[0][15:8]; // [R4]
        `DTEC_ADDR_CNT0_LOW:  next_st.rdata = st.hold[0]; // [R5]
        `DTEC_ADDR_CNT0_CTRL: next_st.rdata = st.ctrl[0] & `DTEC_CTRL_IMPL_MASK; // [R9]
        `DTEC_ADDR_CNT1_HIGH: next_st.rdata = st.count[1][15:8]; // [R4]
        `DTEC_ADDR_CNT1_LOW:  next_st.rdata = st.hold[1]; // [R5]
        `DTEC_ADDR_CNT1_CTRL: next_st.rdata = st.ctrl[1] & `DTEC_CTRL_IMPL_MASK; // [R9]
        `DTEC_ADDR_IRQ_CTRL: begin
          next_st.rdata                      = '0;
          next_st.rdata[`DTEC_IRQ_EN0_BIT]   = st.irq_en[0];
          next_st.rdata[`DTEC_IRQ_EN1_BIT]   = st.irq_en[1];
          next_st.rdata[`DTEC_IRQ_FLAG0_BIT] = st.flag[0];
          next_st.rdata[`DTEC_IRQ_FLAG1_BIT] = st.flag[1];
        end
        default: next_st.rdata = '0;
      endcase
    end

    // A disabled enable masks the request whatever the mode.
    next_st.irq = next_st.flag & next_st.irq_en; // [R17]
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Low clk_en freezes every bit, divider and synchronisers included.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st      <= '0;
      st.ctrl <= {2{`DTEC_CTRL_RST}};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdata       = st.rdata;
  assign irq_request = st.irq;
  assign wake_event  = st.wake;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_hi_write0;
    clk_en && wr && addr == `DTEC_ADDR_CNT0_HIGH;
  endsequence

  sequence s_hi_read0;
    clk_en && rd && addr == `DTEC_ADDR_CNT0_HIGH;
  endsequence

  property p_low_write_buffer_only;
    clk_en && wr && addr == `DTEC_ADDR_CNT0_LOW |=>
      st.hold[0] == $past(wdata) && st.preload[0] == $past(st.preload[0]);
  endproperty
  a_low_write_buffer_only: assert property (p_low_write_buffer_only) // [R2]
    else $error("Low byte write disturbed the preload.");

  property p_high_write_preload;
    s_hi_write0 |=> st.preload[0] == {$past(wdata), $past(st.hold[0])};
  endproperty
  a_high_write_preload: assert property (p_high_write_preload) // [R3]
    else $error("High byte write did not form the preload.");

  property p_high_read_latch;
    s_hi_read0 |=> rdata == $past(st.count[0][15:8]) && st.hold[0] == $past(st.count[0][7:0])
                   && st.count[0] == $past(st.count[0]);
  endproperty
  a_high_read_latch: assert property (p_high_read_latch) // [R4] [R20]
    else $error("High byte read returned or latched the wrong value.");

  property p_low_read_buffer;
    clk_en && rd && addr == `DTEC_ADDR_CNT1_LOW |=> rdata == $past(st.hold[1]);
  endproperty
  a_low_read_buffer: assert property (p_low_read_buffer) // [R5]
    else $error("Low byte read did not return the holding buffer.");

  property p_ctrl_unused_zero;
    clk_en && rd && addr == `DTEC_ADDR_CNT0_CTRL |=> rdata[2:0] == 3'h0 && rdata[5] == 1'b0;
  endproperty
  a_ctrl_unused_zero: assert property (p_ctrl_unused_zero) // [R9]
    else $error("Unimplemented control bits read as one.");

  property p_overflow_reload;
    clk_en && tick[0] && st.count[0] == `DTEC_COUNT_MAX |=>
      st.count[0] == $past(st.preload[0]) && st.flag[0] && wake_event[0] ##1 !wake_event[0] || !clk_en;
  endproperty
  a_overflow_reload: assert property (p_overflow_reload) // [R11] [R16]
    else $error("Overflow did not reload, flag and wake.");

  property p_stopped_load;
    s_hi_write0 and (!st.ctrl[0][`DTEC_CTRL_RUN_BIT]) |=> st.count[0] == st.preload[0];
  endproperty
  a_stopped_load: assert property (p_stopped_load) // [R18]
    else $error("Stopped counter was not loaded with the preload.");

  property p_running_keeps_count;
    s_hi_write0 and (st.ctrl[0][`DTEC_CTRL_RUN_BIT] && !tick[0]) |=> st.count[0] == $past(st.count[0]);
  endproperty
  a_running_keeps_count: assert property (p_running_keeps_count) // [R19]
    else $error("Running counter was overwritten by a preload write.");

  property p_run_held;
    clk_en && st.ctrl[1][`DTEC_CTRL_RUN_BIT] && st.ctrl[1][7:6] != `DTEC_MODE_PULSE
      && !(wr && addr == `DTEC_ADDR_CNT1_CTRL) |=> st.ctrl[1][`DTEC_CTRL_RUN_BIT];
  endproperty
  a_run_held: assert property (p_run_held) // [R15]
    else $error("Hardware cleared run outside pulse mode.");

  property p_pulse_done;
    clk_en && st.pw[0] == dtec_pkg::PW_COUNT && st.ctrl[0][`DTEC_CTRL_RUN_BIT]
      && st.ctrl[0][7:6] == `DTEC_MODE_PULSE && !wr
      && (st.ctrl[0][`DTEC_CTRL_EDGE_BIT] ? (st.pin_prev[0] && !st.pin_s2[0])
                                          : (!st.pin_prev[0] && st.pin_s2[0]))
      |=> !st.ctrl[0][`DTEC_CTRL_RUN_BIT] && st.count[0] == $past(st.count[0]);
  endproperty
  a_pulse_done: assert property (p_pulse_done) // [R12] [R13]
    else $error("Pulse measurement did not stop on the return edge.");

  property p_timer_rate;
    clk_en && st.ctrl[0][7:6] == `DTEC_MODE_TIMER && tick[0] |=> !tick[0] [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) // [R10]
    else $error("Timer ticked faster than the instruction clock.");

  property p_irq_gate;
    !st.irq_en[1] |-> !irq_request[1];
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R17]
    else $error("Interrupt request raised while disabled.");

  property p_flag_set_wins;
    clk_en && ovf[1] |=> st.flag[1] && irq_request[1] == st.irq_en[1];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) // [R11] [R17]
    else $error("Overflow flag lost.");

  property p_wake_single;
    clk_en && wake_event[1] |=> !wake_event[1];
  endproperty
  a_wake_single: assert property (p_wake_single) // [R16]
    else $error("Wake pulse too long.");

  property p_low_write_keeps;
    clk_en && wr && addr == `DTEC_ADDR_CNT1_LOW && !tick[1] |=> $stable(st.count[1]) && $stable(st.preload[1]);
  endproperty
  a_low_write_keeps: assert property (p_low_write_keeps) // [R2]
    else $error("Low byte write moved count or preload.");

  property p_read_blocks;
    clk_en && rd && (addr == `DTEC_ADDR_CNT1_HIGH || addr == `DTEC_ADDR_CNT1_LOW) |=> $stable(st.count[1]);
  endproperty
  a_read_blocks: assert property (p_read_blocks) // [R20]
    else $error("Counter moved during a read.");

  property p_mode_off_still;
    clk_en && st.ctrl[1][7:6] == `DTEC_MODE_OFF && !wr |=> $stable(st.count[1]);
  endproperty
  a_mode_off_still: assert property (p_mode_off_still) // [R6]
    else $error("Counter moved in the unused mode.");

  property p_pulse_start;
    clk_en && st.ctrl[1][7:6] == `DTEC_MODE_PULSE && st.ctrl[1][`DTEC_CTRL_RUN_BIT] && st.pw[1] == dtec_pkg::PW_WAIT
      && (st.ctrl[1][`DTEC_CTRL_EDGE_BIT] ? st.pin_s2[1] && !st.pin_prev[1] : !st.pin_s2[1] && st.pin_prev[1])
      |=> st.pw[1] == dtec_pkg::PW_COUNT;
  endproperty
  a_pulse_start: assert property (p_pulse_start) // [R12]
    else $error("Pulse measurement did not start.");

  property p_count_step;
    clk_en && tick[0] && st.count[0] != `DTEC_COUNT_MAX |=> st.count[0] == $past(st.count[0]) + `DTEC_COUNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) // [R1] [R10]
    else $error("Counter did not step by one.");

endmodule : dtec_top

// File: test/dtec_pin_src.sv
// Behavioural source for one count pin of the dual timer/event counter.
// Assumes the bench pulses go for one mclk cycle and asks for width >= 2.
`timescale 1ns/1ps

module dtec_pin_src (
  // Clock.
  input  wire logic       mclk,
  // Request from the bench.
  input  wire logic       go,
  input  wire logic       idle,
  input  wire logic [7:0] n,
  input  wire logic [7:0] width,
  // Pin and status.
  output logic            pin,
  output logic            busy
);
  // ----------------------------------------------------------------------
  // Pulse burst generator
  // ----------------------------------------------------------------------
  // Each level stands for width cycles, because the counter's two-flop
  // synchroniser silently drops anything narrower than one cycle.
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        busy <= 1'b1;
        repeat (n) begin
          pin <= ~idle;
          repeat (width) @(posedge mclk);
          pin <= idle;
          repeat (width) @(posedge mclk);
        end
        busy <= 1'b0;
      end else begin
        pin <= idle;
      end
    end
  end
endmodule : dtec_pin_src

// File: test/tb.sv
// Self-checking bench for the dual timer/event counter.
// Assumes dtec_top, dtec_pin_src and dtec_defs.svh are on the compile path.
`timescale 1ns/1ps
`include "dtec_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module tb;
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic             clk_en = 1'b1;
  logic [7:0]       addr = 8'h00;
  logic [7:0]       wdata = 8'h00;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [7:0]       rdata;
  logic [1:0]       count_pin;
  logic [1:0]       irq_request;
  logic [1:0]       wake_event;
  logic [1:0]       go = 2'h0;
  logic [1:0]       idle = 2'h0;
  logic [1:0]       busy;
  logic [1:0][7:0]  n = '0;
  logic [1:0][7:0]  width = '0;
  logic [31:0]      seed = 32'h00000011;
  int               wake_cnt [2] = '{0, 0};
  int               errors = 0;
  int               n_tests = 0;

  // ----------------------------------------------------------------------
  // Clock, design and pin sources
  // ----------------------------------------------------------------------
  // The 5 ns period gives 200 MHz.
  always #2.5 mclk = ~mclk;

  dtec_top u_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .count_pin(count_pin), .irq_request(irq_request),
    .wake_event(wake_event));
  dtec_pin_src u_src0 (.mclk(mclk), .go(go[0]), .idle(idle[0]), .n(n[0]), .width(width[0]),
    .pin(count_pin[0]), .busy(busy[0]));
  dtec_pin_src u_src1 (.mclk(mclk), .go(go[1]), .idle(idle[1]), .n(n[1]), .width(width[1]),
    .pin(count_pin[1]), .busy(busy[1]));

  // Wake pulses last one cycle, so they are tallied here rather than polled.
  always @(posedge mclk) begin
    for (int j = 0; j < 2; j++) begin
      if (wake_event[j] === 1'b1) wake_cnt[j]++;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers: random source, addressing and register port cycles
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rand32();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rand32

  // Offset 0 is the high byte, 1 the low byte and 2 the control register.
  function automatic logic [7:0] adr(input int i, input int k);
    return 8'(`DTEC_ADDR_CNT0_HIGH + 3 * i + k);
  endfunction : adr

  function automatic logic [7:0] ctl(input int m, input int r, input int e);
    return 8'((m << 6) | (r << 4) | (e << 3));
  endfunction : ctl

  // Each cycle starts on a fresh edge so a strobe is never driven twice at once.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    reg_rd(a, v);
    `CHK(nm, e, v)
  endtask : rchk

  // Low byte first, since the high-byte write commits the pair.
  task automatic set16(input int i, input logic [15:0] v);
    reg_wr(adr(i, 1), v[7:0]);
    reg_wr(adr(i, 0), v[15:8]);
  endtask : set16

  task automatic pulses(input int i, input logic [7:0] nn, input logic [7:0] w);
    n[i] <= nn;
    width[i] <= w;
    go[i] <= 1'b1;
    @(posedge mclk);
    go[i] <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 3000 && busy[i] === 1'b1; k++) @(posedge mclk);
    repeat (8) @(posedge mclk);
  endtask : pulses

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  // The tests need some 1,000 cycles; 80,000 leaves ample margin.
  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [7:0]  u;
    logic [7:0]  h;
    logic [7:0]  l;
    int          nn;
    int          w0;
    int          w1;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // A write while clk_en is low is ignored; ctrl_reset below sees it.
    clk_en <= 1'b0;
    reg_wr(adr(0, 2), 8'hFF);
    clk_en <= 1'b1;
    // Reset values, unmapped space and the bits that always read zero.
    rchk(`DTEC_ADDR_IRQ_CTRL, 8'h00, "irq_ctrl_reset");
    rchk(8'h20, 8'h00, "unmapped");
    for (int i = 0; i < 2; i++) begin
      rchk(adr(i, 2), `DTEC_CTRL_RST, "ctrl_reset");
      reg_wr(adr(i, 2), 8'hFF);
      rchk(adr(i, 2), `DTEC_CTRL_IMPL_MASK, "ctrl_mask");
      reg_wr(adr(i, 2), 8'h00);
    end
    $display("Test registers done");
    // Preload while stopped, byte buffer, latched reads; mode 00 must not count.
    for (int i = 0; i < 2; i++) begin
      v = 16'(rand32());
      u = 8'(rand32());
      set16(i, v);
      reg_wr(adr(i, 2), ctl(0, 1, 0));
      repeat (40) @(posedge mclk);
      reg_wr(adr(i, 2), ctl(0, 0, 0));
      rchk(adr(i, 0), v[15:8], "count_hi");
      rchk(adr(i, 1), v[7:0], "count_lo");
      reg_wr(adr(i, 1), u);
      rchk(adr(i, 1), u, "buffer");
      rchk(adr(i, 0), v[15:8], "count_hi_kept");
      rchk(adr(i, 1), v[7:0], "count_lo_latched");
    end
    $display("Test byte buffer done");
    // Event counting on each edge: one lone rise, then falls and rises in pairs.
    for (int i = 0; i < 2; i++) begin
      for (int e = 0; e < 2; e++) begin
        set16(i, 16'h0000);
        reg_wr(adr(i, 2), ctl(1, 1, e));
        idle[i] <= 1'b1;
        repeat (8) @(posedge mclk);
        nn = 1 + int'(rand32() % 8);
        pulses(i, 8'(nn), 8'h03);
        reg_wr(adr(i, 2), ctl(1, 0, e));
        rchk(adr(i, 0), 8'h00, "event_hi");
        rchk(adr(i, 1), 8'(nn + (e == 0)), "event_count");
        idle[i] <= 1'b0;
        repeat (8) @(posedge mclk);
      end
    end
    $display("Test event count done");
    // Counter 0 times a high pulse, counter 1 a low one; 40 cycles wrap once.
    for (int i = 0; i < 2; i++) begin
      idle[i] <= (i == 1);
      set16(i, 16'hFFF8);
      reg_wr(adr(i, 2), ctl(3, 1, i == 0));
      w0 = wake_cnt[i];
      pulses(i, 8'h01, 8'h28);
      rchk(adr(i, 2), ctl(3, 0, i == 0), "pulse_run_clear");
      reg_rd(adr(i, 0), h);
      reg_rd(adr(i, 1), l);
      `CHK("pulse_width", 1, int'({h, l} >= 16'hFFF9 && {h, l} <= 16'hFFFB))
      `CHK("pulse_wake", w0 + 1, wake_cnt[i])
      pulses(i, 8'h01, 8'h28);
      rchk(adr(i, 0), h, "pulse_hold_hi");
      rchk(adr(i, 1), l, "pulse_hold_lo");
    end
    $display("Test pulse width done");
    // Timer overflow with a preload rewritten while running.
    for (int i = 0; i < 2; i++) begin
      reg_wr(`DTEC_ADDR_IRQ_CTRL, 8'(1 << i));
      set16(i, 16'hFFF0);
      reg_wr(adr(i, 2), ctl(2, 1, 0));
      set16(i, 16'h1200);
      w0 = wake_cnt[i];
      w1 = wake_cnt[1 - i];
      for (int k = 0; k < 300 && wake_cnt[i] == w0; k++) @(posedge mclk);
      repeat (3) @(posedge mclk);
      `CHK("timer_wake", w0 + 1, wake_cnt[i])
      `CHK("other_wake", w1, wake_cnt[1 - i])
      `CHK("irq_request", 2'(1 << i), irq_request)
      rchk(`DTEC_ADDR_IRQ_CTRL, 8'((1 << i) | (8'h20 << i)), "irq_flag");
      rchk(adr(i, 2), ctl(2, 1, 0), "timer_run_kept");
      reg_wr(adr(i, 2), ctl(2, 0, 0));
      rchk(adr(i, 0), 8'h12, "reload_hi");
      reg_wr(`DTEC_ADDR_IRQ_CTRL, 8'(8'h20 << i));
      repeat (3) @(posedge mclk);
      `CHK("irq_masked", 2'b00, irq_request)
      reg_wr(`DTEC_ADDR_IRQ_CTRL, 8'h00);
    end
    $display("Test timer overflow done");
    print_verdict();
  end
endmodule : tb
